/* rtl/psm_pkg.sv */
// package: constants, register map and carrier types of the safety monitor
package psm_pkg;
  // register byte addresses on the lite bus
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h004;
  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PNP_BIT = 1;
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic CTRL_PNP_RST = 1'h0;
  // status register fields
  localparam int STAT_ON_BIT = 0;
  localparam int STAT_PULSE_BIT = 1;
  localparam int STAT_TFLT_BIT = 2;
  localparam int STAT_XFLT_BIT = 3;
  localparam int STAT_RUN_LSB = 4;
  localparam int STAT_AUTO_BIT = 6;
  localparam int STAT_ONECH_BIT = 7;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing, figures in ms and the derived cycle counts at the system clock
  localparam int CLK_KHZ = 200000;
  localparam int PULSE_HIGH_MS = 100;
  localparam int PULSE_LOW_MS = 40;
  localparam int LAG_MAX_MS = 20;
  localparam int PULSE_HIGH_CYC = PULSE_HIGH_MS * CLK_KHZ;
  localparam int PULSE_LOW_CYC = PULSE_LOW_MS * CLK_KHZ;
  localparam int LAG_MAX_CYC = LAG_MAX_MS * CLK_KHZ;
  localparam int PHASE_CNT_W = 25;
  // safety sequencing states
  typedef enum logic [1:0] {stIdle, stStartHeld, stOn, stLockout} psm_run_type;
  // terminals and straps as seen at the pins
  typedef struct packed {
    logic firstSensor;
    logic secondSensor;
    logic startButton;
    logic andChainIn;
    logic autoStrap;
    logic oneChanStrap;
    logic andCfgBridged;
  } psm_pins_type;
  // lite bus, master to slave
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } psm_axi_req_type;
  // lite bus, slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } psm_axi_resp_type;
  // whole state of the monitor
  typedef struct packed {
    psm_pins_type sync1;
    psm_pins_type sync2;
    logic ctrlEn;
    logic ctrlPnp;
    logic [PHASE_CNT_W-1:0] phaseCnt;
    logic phaseHigh;
    logic secondHeld;
    logic testFault;
    logic crossFault;
    psm_run_type run;
    logic [1:0] safeOut;
    logic testPulse;
    psm_axi_resp_type bus;
  } psm_state_type;
  // state after reset
  localparam psm_state_type STATE_RST = '{
    sync1: '0, sync2: '0, ctrlEn: CTRL_EN_RST, ctrlPnp: CTRL_PNP_RST,
    phaseCnt: '0, phaseHigh: 1'h1, secondHeld: 1'h0, testFault: 1'h0,
    crossFault: 1'h0, run: stIdle, safeOut: 2'h0, testPulse: 1'h1, bus: '0};
endpackage

/* rtl/psm_monitor.sv */
// protective sensor safety monitor with lite-bus control and status
`timescale 1ns/10ps
module psm_monitor #(
  parameter int PULSE_HIGH_CYC = psm_pkg::PULSE_HIGH_CYC,
  parameter int PULSE_LOW_CYC = psm_pkg::PULSE_LOW_CYC,
  parameter int LAG_MAX_CYC = psm_pkg::LAG_MAX_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire psm_pkg::psm_pins_type pinsIn,
  input wire psm_pkg::psm_axi_req_type axiReq,
  output psm_pkg::psm_axi_resp_type axiResp,
  output logic [1:0] safetyOut,
  output logic testPulseOut
);

  // cycle limits at counter width
  localparam logic [psm_pkg::PHASE_CNT_W-1:0] HIGH_LAST =
    psm_pkg::PHASE_CNT_W'(PULSE_HIGH_CYC - 1);
  localparam logic [psm_pkg::PHASE_CNT_W-1:0] LOW_LAST =
    psm_pkg::PHASE_CNT_W'(PULSE_LOW_CYC - 1);
  localparam logic [psm_pkg::PHASE_CNT_W-1:0] LAG_LIM =
    psm_pkg::PHASE_CNT_W'(LAG_MAX_CYC);

  // register selects from the address decoder
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_NONE = 2'h2;

  psm_pkg::psm_state_type st_ff; // registered state
  psm_pkg::psm_state_type nxt_st; // next state

  // address decode, shared by write and read paths
  function automatic logic [1:0] regSel(input logic [psm_pkg::ADDR_W-1:0] addr);
    logic [1:0] sel;
    sel = SEL_NONE;
    // word addresses only; low bits ignored as the bus allows
    if ({addr[psm_pkg::ADDR_W-1:2], 2'h0} == psm_pkg::CTRL_ADDR) begin
      sel = SEL_CTRL;
    end else if ({addr[psm_pkg::ADDR_W-1:2], 2'h0} == psm_pkg::STATUS_ADDR) begin
      sel = SEL_STATUS;
    end
    return sel;
  endfunction

  // status word built from the registered state
  function automatic logic [31:0] statusWord(input psm_pkg::psm_state_type s);
    logic [31:0] w;
    w = 32'h0;
    w[psm_pkg::STAT_ON_BIT] = s.safeOut[0];
    w[psm_pkg::STAT_PULSE_BIT] = s.testPulse;
    w[psm_pkg::STAT_TFLT_BIT] = s.testFault;
    w[psm_pkg::STAT_XFLT_BIT] = s.crossFault;
    w[psm_pkg::STAT_RUN_LSB +: 2] = s.run;
    w[psm_pkg::STAT_AUTO_BIT] = s.sync2.autoStrap;
    w[psm_pkg::STAT_ONECH_BIT] = s.sync2.oneChanStrap;
    return w;
  endfunction

  // working signals of the next-state logic
  logic oneChan; // one-channel operation selected
  logic autoStart; // automatic start selected
  logic pulsing; // test pulse output toggling
  logic settled; // echo lag window has passed
  logic firstIn; // synchronised first input
  logic secondIn; // synchronised second input
  logic sensorOk; // all evaluated channels active
  logic bothLow; // all evaluated channels inactive
  logic chainOk; // upstream unit enables us
  logic permit; // nothing forbids the outputs
  logic wrTake; // write handshake this cycle
  logic rdTake; // read handshake this cycle
  logic [1:0] wrSel; // decoded write target
  logic [1:0] rdSel; // decoded read target
  logic swClrTest; // software clears the echo fault

  // next-state logic of the whole monitor
  always_comb begin
    nxt_st = st_ff;

    // two-stage synchronisers for every pin
    nxt_st.sync1 = pinsIn;
    nxt_st.sync2 = st_ff.sync1;

    // configuration straps and inputs after synchronising
    autoStart = st_ff.sync2.autoStrap;
    oneChan = st_ff.sync2.oneChanStrap;
    firstIn = st_ff.sync2.firstSensor;
    secondIn = st_ff.sync2.secondSensor;

    // pulse runs in one-channel mode and on relay-contact pairs
    pulsing = oneChan | ~st_ff.ctrlPnp;

    // ---- bus write path ----
    wrTake = st_ff.bus.awready & st_ff.bus.wready;
    wrSel = regSel(axiReq.awaddr);
    swClrTest = 1'h0;
    // ready pulses once both address and data are offered
    nxt_st.bus.awready = axiReq.awvalid & axiReq.wvalid & ~st_ff.bus.bvalid &
      ~st_ff.bus.awready;
    nxt_st.bus.wready = nxt_st.bus.awready;
    // response drops when the master takes it
    if (st_ff.bus.bvalid & axiReq.bready) begin
      nxt_st.bus.bvalid = 1'h0;
    end
    // perform the write on the handshake edge
    if (wrTake) begin
      nxt_st.bus.bvalid = 1'h1;
      nxt_st.bus.bresp = psm_pkg::RESP_OKAY;
      if (wrSel == SEL_CTRL) begin
        // control bits live in byte lane 0
        if (axiReq.wstrb[0]) begin
          nxt_st.ctrlEn = axiReq.wdata[psm_pkg::CTRL_EN_BIT];
          nxt_st.ctrlPnp = axiReq.wdata[psm_pkg::CTRL_PNP_BIT];
        end
      end else if (wrSel == SEL_STATUS) begin
        // writing one to the echo fault bit clears it
        swClrTest = axiReq.wstrb[0] & axiReq.wdata[psm_pkg::STAT_TFLT_BIT];
      end else begin
        // unmapped address
        nxt_st.bus.bresp = psm_pkg::RESP_SLVERR;
      end
    end

    // ---- bus read path ----
    rdTake = st_ff.bus.arready;
    rdSel = regSel(axiReq.araddr);
    // ready pulses once per accepted read
    nxt_st.bus.arready = axiReq.arvalid & ~st_ff.bus.rvalid & ~st_ff.bus.arready;
    // data drops when the master takes it
    if (st_ff.bus.rvalid & axiReq.rready) begin
      nxt_st.bus.rvalid = 1'h0;
    end
    // capture read data on the handshake edge
    if (rdTake) begin
      nxt_st.bus.rvalid = 1'h1;
      nxt_st.bus.rresp = psm_pkg::RESP_OKAY;
      nxt_st.bus.rdata = 32'h0;
      if (rdSel == SEL_CTRL) begin
        nxt_st.bus.rdata[psm_pkg::CTRL_EN_BIT] = st_ff.ctrlEn;
        nxt_st.bus.rdata[psm_pkg::CTRL_PNP_BIT] = st_ff.ctrlPnp;
      end else if (rdSel == SEL_STATUS) begin
        nxt_st.bus.rdata = statusWord(st_ff);
      end else begin
        // unmapped address reads zero with an error
        nxt_st.bus.rresp = psm_pkg::RESP_SLVERR;
      end
    end

    // ---- test pulse generator ----
    if (!pulsing) begin
      // steady supply level when no pulse is needed
      nxt_st.phaseCnt = '0;
      nxt_st.phaseHigh = 1'h1;
    end else if (st_ff.phaseHigh && st_ff.phaseCnt == HIGH_LAST) begin
      // end of the high phase
      nxt_st.phaseCnt = '0;
      nxt_st.phaseHigh = 1'h0;
    end else if (!st_ff.phaseHigh && st_ff.phaseCnt == LOW_LAST) begin
      // end of the low phase
      nxt_st.phaseCnt = '0;
      nxt_st.phaseHigh = 1'h1;
    end else begin
      nxt_st.phaseCnt = st_ff.phaseCnt + psm_pkg::PHASE_CNT_W'(1);
    end
    nxt_st.testPulse = nxt_st.phaseHigh;

    // echo is only judged once the allowed lag has passed
    settled = pulsing & (st_ff.phaseCnt >= LAG_LIM);

    // second input sampled in the settled high phase only, or every cycle while the pulse is off
    if (!pulsing) begin
      nxt_st.secondHeld = secondIn;
    end else if (st_ff.phaseHigh && settled) begin
      nxt_st.secondHeld = secondIn;
    end

    // ---- echo and cross-circuit faults ----
    // clear first so that a fresh fault wins over the clear
    if (swClrTest) begin
      nxt_st.testFault = 1'h0;
    end
    if (!st_ff.phaseHigh && settled) begin
      if (oneChan) begin
        // sensor output stuck high while the pulse is low
        if (secondIn) begin
          nxt_st.testFault = 1'h1;
        end
      end else if (secondIn && firstIn) begin
        // second channel held up by the first one
        nxt_st.crossFault = 1'h1;
      end else if (!secondIn) begin
        // short has gone, channel follows the pulse again
        nxt_st.crossFault = 1'h0;
      end
    end

    // ---- channel evaluation ----
    // one-channel mode ignores the first input entirely
    if (oneChan) begin
      sensorOk = st_ff.secondHeld;
      bothLow = ~st_ff.secondHeld;
    end else begin
      sensorOk = firstIn & st_ff.secondHeld;
      bothLow = ~firstIn & ~st_ff.secondHeld;
    end
    // chain input matters only when its config terminal is open
    chainOk = st_ff.sync2.andCfgBridged | st_ff.sync2.andChainIn;
    permit = st_ff.ctrlEn & chainOk & ~st_ff.testFault & ~st_ff.crossFault;

    // ---- safety sequencing ----
    unique case (st_ff.run)
      psm_pkg::stIdle: begin
        if (permit && sensorOk && autoStart) begin
          // automatic start, no button needed
          nxt_st.run = psm_pkg::stOn;
        end else if (permit && sensorOk && st_ff.sync2.startButton) begin
          // start closed; contactor contacts sit in its loop
          nxt_st.run = psm_pkg::stStartHeld;
        end
      end
      psm_pkg::stStartHeld: begin
        if (!permit || !sensorOk) begin
          // sensors dropped before release, start again
          nxt_st.run = psm_pkg::stIdle;
        end else if (!st_ff.sync2.startButton) begin
          // start reopened with sensors still active
          nxt_st.run = psm_pkg::stOn;
        end
      end
      psm_pkg::stOn: begin
        if (!permit || !sensorOk) begin
          // beam broken, chain lost or fault: our outputs only
          if (st_ff.ctrlPnp || oneChan) begin
            nxt_st.run = psm_pkg::stLockout;
          end else begin
            nxt_st.run = psm_pkg::stIdle;
          end
        end
      end
      psm_pkg::stLockout: begin
        // restart blocked until all channels go low together and the echo fault is clear
        if (bothLow && !st_ff.testFault) begin
          nxt_st.run = psm_pkg::stIdle;
        end
      end
    endcase

    // outputs follow the sequencer state
    nxt_st.safeOut = {2{nxt_st.run == psm_pkg::stOn}};
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_ff <= psm_pkg::STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign axiResp = st_ff.bus;
  assign safetyOut = st_ff.safeOut;
  assign testPulseOut = st_ff.testPulse;

endmodule

/* sim/psm_sva.sv */
// checker: port-level assertions of the safety monitor
`timescale 1ns/10ps
module psm_sva #(
  parameter int PULSE_HIGH_CYC = 100,
  parameter int PULSE_LOW_CYC = 40
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire psm_pkg::psm_pins_type pinsIn,
  input wire psm_pkg::psm_axi_req_type axiReq,
  input wire psm_pkg::psm_axi_resp_type axiResp,
  input wire logic [1:0] safetyOut,
  input wire logic testPulseOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic prevTp_ff; // pulse level one cycle ago
  logic seen_ff; // a whole phase is being counted
  logic [31:0] runCnt_ff; // cycles spent at the present level
  // phase length counter, the first phase after reset is not judged
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prevTp_ff <= 1'h1;
      seen_ff <= 1'h0;
      runCnt_ff <= 32'h0;
    end else begin
      prevTp_ff <= testPulseOut;
      if (testPulseOut != prevTp_ff) begin
        runCnt_ff <= 32'h1;
        seen_ff <= 1'h1;
      end else begin
        runCnt_ff <= runCnt_ff + 32'h1;
      end
    end
  end
  a_outs_equal: assert property (safetyOut[0] == safetyOut[1])
    else $error("safety output bits differ");
  a_first_trip: assert property ((!pinsIn.oneChanStrap && !pinsIn.firstSensor) [*4]
    |=> ##[0:2] safetyOut == 2'h0) else $error("outputs on with first channel open");
  a_chain_drop: assert property ((!pinsIn.andCfgBridged && !pinsIn.andChainIn) [*4]
    |=> ##[0:2] safetyOut == 2'h0) else $error("outputs on with chain input low");
  a_pulse_high: assert property (seen_ff && prevTp_ff && !testPulseOut
    |-> runCnt_ff == PULSE_HIGH_CYC) else $error("test pulse high phase length wrong");
  a_pulse_low: assert property (seen_ff && !prevTp_ff && testPulseOut
    |-> runCnt_ff == PULSE_LOW_CYC) else $error("test pulse low phase length wrong");
  a_write_resp: assert property (axiResp.awready && axiResp.wready |=> axiResp.bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (axiResp.bvalid && !axiReq.bready
    |=> axiResp.bvalid && $stable(axiResp.bresp)) else $error("write response dropped");
  a_read_resp: assert property (axiResp.arready |=> axiResp.rvalid)
    else $error("read response late");
  a_rdata_hold: assert property (axiResp.rvalid && !axiReq.rready
    |=> axiResp.rvalid && $stable(axiResp.rdata)) else $error("read data dropped");
  a_unmapped_err: assert property (axiResp.arready && axiReq.araddr[11:2] > 10'h1
    |=> axiResp.rresp == psm_pkg::RESP_SLVERR) else $error("unmapped read not refused");
endmodule
bind psm_monitor psm_sva #(.PULSE_HIGH_CYC(PULSE_HIGH_CYC), .PULSE_LOW_CYC(PULSE_LOW_CYC))
  chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .pinsIn(pinsIn), .axiReq(axiReq),
  .axiResp(axiResp), .safetyOut(safetyOut), .testPulseOut(testPulseOut));

/* sim/psm_sensor_model.sv */
// light barrier sensor model answering the monitor's test pulse
`timescale 1ns/10ps
module psm_sensor_model (
  input wire logic sys_clk,
  input wire logic testPulse,
  input wire logic [1:0] beam,
  input wire logic oneChan,
  input wire logic pnpMode,
  input wire logic stuck,
  output logic firstOut,
  output logic secondOut
);
  logic [3:0] echo_ff = 4'h0; // returned pulse, well inside the lag limit
  logic flip_ff = 1'h0; // stands for the loose first input
  // echo line and float pattern
  always_ff @(posedge sys_clk) begin
    echo_ff <= {echo_ff[2:0], testPulse};
    flip_ff <= ~flip_ff;
  end
  // stuck: second line stays up, a short or a dead echo
  assign secondOut = beam[1] & (pnpMode | stuck | echo_ff[3]);
  // unconnected in one-channel use, so never a steady level
  assign firstOut = oneChan ? flip_ff : beam[0];
endmodule

/* sim/testbench.sv */
// self-checking bench of the safety monitor
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module testbench;
  logic sys_clk, sys_rst, testPulseOut, mFirst, mSecond, btn, chainIn, autoS, oneS, cfgB;
  logic stuck, pnpM;
  logic [1:0] beam, safetyOut, r;
  logic [31:0] d;
  psm_pkg::psm_axi_req_type req;
  psm_pkg::psm_axi_resp_type resp;
  int mismatches, n_compared;
  // start loop sees contactor feedback: closed only while outputs are off
  wire psm_pkg::psm_pins_type pins = {mFirst, mSecond, btn & ~safetyOut[0], chainIn, autoS,
    oneS, cfgB};
  psm_monitor #(.PULSE_HIGH_CYC(100), .PULSE_LOW_CYC(40), .LAG_MAX_CYC(20)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .pinsIn(pins), .axiReq(req), .axiResp(resp),
    .safetyOut(safetyOut), .testPulseOut(testPulseOut));
  psm_sensor_model sens_u (.sys_clk(sys_clk), .testPulse(testPulseOut), .beam(beam),
    .oneChan(oneS), .pnpMode(pnpM), .stuck(stuck), .firstOut(mFirst), .secondOut(mSecond));
  // clock
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // verdict
  task wrap_up;
    $display("Compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bus write, waits for the slave under a bound
  task axi_wr(input logic [11:0] a, input logic [31:0] wd);
    int i;
    i = 0;
    req.awvalid <= 1; req.awaddr <= a; req.wvalid <= 1; req.wdata <= wd; req.bready <= 1;
    req.wstrb <= 4'hf;
    do begin @(posedge sys_clk); i++; end while (resp.awready !== 1'b1 && i < 50);
    req.awvalid <= 0; req.wvalid <= 0;
    do begin @(posedge sys_clk); i++; end while (resp.bvalid !== 1'b1 && i < 50);
    r = resp.bresp; req.bready <= 0;
    if (i >= 50) begin mismatches++; wrap_up(); end
    @(posedge sys_clk);
  endtask
  // bus read
  task axi_rd(input logic [11:0] a);
    int i;
    i = 0;
    req.arvalid <= 1; req.araddr <= a; req.rready <= 1;
    do begin @(posedge sys_clk); i++; end while (resp.arready !== 1'b1 && i < 50);
    req.arvalid <= 0;
    do begin @(posedge sys_clk); i++; end while (resp.rvalid !== 1'b1 && i < 50);
    r = resp.rresp; d = resp.rdata; req.rready <= 0;
    if (i >= 50) begin mismatches++; wrap_up(); end
    @(posedge sys_clk);
  endtask
  // wait for an output level under a bound
  task wait_out(input logic [1:0] e);
    int i;
    for (i = 0; i < 600 && safetyOut !== e; i++) @(posedge sys_clk);
    `CHK("safetyOut", e, safetyOut)
    if (i == 600) wrap_up();
  endtask
  // output must hold a level for n cycles
  task stay_out(input logic [1:0] e, input int n);
    logic bad;
    bad = 0;
    repeat (n) begin @(posedge sys_clk); if (safetyOut !== e) bad = 1; end
    `CHK("safetyHeld", 1'b0, bad)
  endtask
  // reset with given straps and sensor type
  task setup(input logic a, input logic o, input logic p);
    sys_rst <= 1; autoS <= a; oneS <= o; pnpM <= p; beam <= 0; stuck <= 0; btn <= 0;
    chainIn <= 1; cfgB <= 1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    axi_wr(psm_pkg::CTRL_ADDR, {30'h0, p, 1'b1});
  endtask
  // start button closed then reopened
  task press;
    btn <= 1; repeat (10) @(posedge sys_clk); btn <= 0;
  endtask
  task t_regs;
    setup(1, 1, 0);
    axi_rd(psm_pkg::STATUS_ADDR);
    `CHK("strapBits", 2'h3, d[7:6])
    axi_rd(12'h010);
    `CHK("unmappedRd", psm_pkg::RESP_SLVERR, r)
    axi_wr(12'h010, 32'h0);
    `CHK("unmappedWr", psm_pkg::RESP_SLVERR, r)
    $display("t_regs done");
  endtask
  task t_monitored;
    setup(0, 0, 0); beam <= 3;
    stay_out(2'h0, 200);
    press(); wait_out(2'h3);
    beam <= 0; wait_out(2'h0);
    $display("t_monitored done");
  endtask
  task t_auto_chain;
    setup(1, 0, 0); cfgB <= 0; beam <= 3;
    wait_out(2'h3);
    chainIn <= 0; wait_out(2'h0);
    $display("t_auto_chain done");
  endtask
  task t_pnp;
    setup(1, 0, 1); beam <= 3;
    wait_out(2'h3);
    beam <= 2'h2; wait_out(2'h0);
    beam <= 3; stay_out(2'h0, 100);
    beam <= 0; repeat (10) @(posedge sys_clk); beam <= 3;
    wait_out(2'h3);
    $display("t_pnp done");
  endtask
  task t_onech;
    setup(0, 1, 0); beam <= 2'h2;
    stay_out(2'h0, 150);
    press(); wait_out(2'h3);
    stuck <= 1; wait_out(2'h0);
    stuck <= 0; stay_out(2'h0, 300);
    axi_rd(psm_pkg::STATUS_ADDR);
    `CHK("echoFault", 1'b1, d[2])
    // software clear of the echo fault once the stuck line is gone
    axi_wr(psm_pkg::STATUS_ADDR, 32'h4);
    axi_rd(psm_pkg::STATUS_ADDR);
    `CHK("echoClr", 1'b0, d[2])
    setup(1, 1, 0); beam <= 2'h2;
    wait_out(2'h3);
    $display("t_onech done");
  endtask
  task t_cross;
    setup(1, 0, 0); stuck <= 1; beam <= 3;
    // the short is only seen once the first low phase has been judged
    repeat (150) @(posedge sys_clk);
    stay_out(2'h0, 300);
    axi_rd(psm_pkg::STATUS_ADDR);
    `CHK("crossFault", 1'b1, d[3])
    stuck <= 0; wait_out(2'h3);
    $display("t_cross done");
  endtask
  // main sequence
  initial begin
    req = '0; sys_rst = 1; autoS = 0; oneS = 0; pnpM = 0; beam = 0; stuck = 0; btn = 0;
    chainIn = 1; cfgB = 1; mismatches = 0; n_compared = 0;
    repeat (5) @(posedge sys_clk);
    t_regs();
    t_monitored();
    t_auto_chain();
    t_pnp();
    t_onech();
    t_cross();
    wrap_up();
  end
endmodule
